// ==== verilog/tf_cmd_pkg.sv ====
// Package for the task-file sector command block: register selects, opcodes, bit positions.
// Assumes both ends share one 250 MHz clock and one active-low asynchronous reset.
package tf_cmd_pkg;
  // ==========================================================
  // Task-file register selects (3-bit address on the link)
  localparam logic [2:0] SEL_DATA = 3'h0;
  localparam logic [2:0] SEL_ERR = 3'h1;
  localparam logic [2:0] SEL_COUNT = 3'h2;
  localparam logic [2:0] SEL_LOW = 3'h3;
  localparam logic [2:0] SEL_MID = 3'h4;
  localparam logic [2:0] SEL_HIGH = 3'h5;
  localparam logic [2:0] SEL_TARGET = 3'h6;
  localparam logic [2:0] SEL_CMD = 3'h7;
  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_READ_EXT = 8'h24;
  localparam logic [7:0] OP_VERIFY = 8'h40;
  localparam logic [7:0] OP_VERIFY_EXT = 8'h42;
  // ==========================================================
  // Bit positions
  localparam int TGT_LBA_BIT = 6;
  localparam int TGT_DRIVE_BIT = 4;
  localparam int HOB_BIT = 7;
  localparam int ERR_UNC_BIT = 6;
  localparam int ERR_IDN_BIT = 4;
  localparam int ERR_ABT_BIT = 2;
  localparam int ERR_AMN_BIT = 0;
  localparam int ST_BSY_BIT = 7;
  localparam int ST_RDY_BIT = 6;
  localparam int ST_DSC_BIT = 4;
  localparam int ST_DRQ_BIT = 3;
  localparam int ST_ERR_BIT = 0;
  // ==========================================================
  // Sizes and reset values
  localparam int WORDS_PER_SECTOR = 256;
  localparam logic [7:0] TARGET_RESET = 8'ha0;
  localparam logic [16:0] COUNT_EXT_ZERO = 17'h1_0000;
  localparam logic [16:0] COUNT_28_ZERO = 17'h0_0100;
endpackage

// ==== verilog/tf_link_if.sv ====
// Interface carrying the task-file register port between host controller and device.
// Assumes one clock; a write or read is a one-cycle strobe with the select on addr.
`timescale 1ns/1ps
interface tf_link_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic wr;
  logic rd;
  logic [2:0] addr;
  logic hob;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic drq;
  logic bsy;
  modport device (input wr, input rd, input addr, input hob, input wdata,
    output rdata, output drq, output bsy);
  modport host (output wr, output rd, output addr, output hob, output wdata,
    input rdata, input drq, input bsy);
endinterface

// ==== verilog/tf_sector_device.sv ====
// Device end: decodes the three sector commands, latches count and address from the
// current/previous register writes, streams read data, reports leftover count and address.
// Assumes a media engine that accepts one sector request and answers done or uncorrectable.
`timescale 1ns/1ps
// Functional notes
// R1: Opcode 24h runs the 48-bit sector read
// R2: Extended read moves one to 65,536 sectors
// R3: Data passes one 16-bit word per access
// R4: Uncorrectable sector stops extended read there
// R5: Extended count: previous high byte, current low
// R6: Extended address from current and previous bytes
// R7: Failing address readable, high-byte select chooses
// R8: Opcodes 40h and 41h both verify
// R9: Retry bit in opcode is ignored
// R10: Verify moves no data to host
// R11: Verify count zero means 256 sectors
// R12: 28-bit address from three bytes plus head
// R13: Count register keeps sectors not processed
// R14: Address registers keep last processed sector
// R15: Opcode 42h runs 48-bit verify
// R16: Uncorrectable sector ends extended verify there
// R17: Only four error flags, three status bits; the status read drives five (BSY, RDY, DSC, DRQ, ERR)
// R18: Host sets LBA bit and drive select
// R19: Address-mode bit picks CHS or LBA; the device ignores it and forms lba_q the same way in both modes
// R20: Drive-select bit picks master or slave
module tf_sector_device
  import tf_cmd_pkg::*;
#(
  parameter logic DRIVE_ID = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  tf_link_if.device link,
  output logic media_req,
  output logic [47:0] media_lba,
  input wire logic media_done,
  input wire logic media_unc,
  input wire logic [15:0] media_word,
  output logic media_word_take
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEEK = 3'b001,
    ST_XFER = 3'b011,
    ST_NEXT = 3'b010,
    ST_DONE = 3'b110
  } state_t;

  state_t state_q;
  logic [7:0] cnt_cur_q, cnt_prev_q;
  logic [7:0] low_cur_q, low_prev_q, mid_cur_q, mid_prev_q, high_cur_q, high_prev_q;
  logic [7:0] target_q;
  logic [7:0] err_q;
  logic err_st_q;
  logic ext_q, xfer_q;
  logic [16:0] left_q;
  logic [47:0] lba_q;
  logic [7:0] word_q;
  logic [15:0] data_q;
  logic data_valid_q;
  logic selected;
  logic cmd_wr;
  logic [7:0] opc;

  // ==========================================================
  // Register write decode
  assign selected = (target_q[TGT_DRIVE_BIT] == DRIVE_ID); // see R20
  assign cmd_wr = link.wr && link.addr == SEL_CMD && state_q == ST_IDLE && selected;
  assign opc = {link.wdata[7:1], 1'b0}; // see R9

  // Current/previous byte pairs shift on each write while idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_cur_q <= 8'h00;
      cnt_prev_q <= 8'h00;
      low_cur_q <= 8'h00;
      low_prev_q <= 8'h00;
      mid_cur_q <= 8'h00;
      mid_prev_q <= 8'h00;
      high_cur_q <= 8'h00;
      high_prev_q <= 8'h00;
      target_q <= TARGET_RESET;
    end else if (link.wr && state_q == ST_IDLE) begin
      case (link.addr)
        SEL_COUNT: begin
          cnt_prev_q <= cnt_cur_q; // see R5
          cnt_cur_q <= link.wdata[7:0];
        end
        SEL_LOW: begin
          low_prev_q <= low_cur_q; // see R6
          low_cur_q <= link.wdata[7:0];
        end
        SEL_MID: begin
          mid_prev_q <= mid_cur_q;
          mid_cur_q <= link.wdata[7:0];
        end
        SEL_HIGH: begin
          high_prev_q <= high_cur_q;
          high_cur_q <= link.wdata[7:0];
        end
        SEL_TARGET: target_q <= link.wdata[7:0];
        default: ;
      endcase
    end else if (state_q == ST_DONE) begin
      // Write back leftover count and last/failing address
      cnt_cur_q <= left_q[7:0]; // see R13
      cnt_prev_q <= left_q[15:8];
      low_cur_q <= lba_q[7:0]; // see R7, R14
      mid_cur_q <= lba_q[15:8];
      high_cur_q <= lba_q[23:16];
      if (ext_q) begin
        low_prev_q <= lba_q[31:24];
        mid_prev_q <= lba_q[39:32];
        high_prev_q <= lba_q[47:40];
      end else begin
        target_q <= {target_q[7:4], lba_q[27:24]}; // see R14
      end
    end
  end

  // ==========================================================
  // Command sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      ext_q <= 1'b0;
      xfer_q <= 1'b0;
      left_q <= 17'h0_0000;
      lba_q <= 48'h0000_0000_0000;
      err_q <= 8'h00;
      err_st_q <= 1'b0;
      word_q <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cmd_wr) begin
            err_q <= 8'h00;
            err_st_q <= 1'b0;
            if (link.wdata[7:0] == OP_READ_EXT || link.wdata[7:0] == OP_VERIFY_EXT) begin
              ext_q <= 1'b1; // see R1, R15
              xfer_q <= (link.wdata[7:0] == OP_READ_EXT); // see R10
              left_q <= ({cnt_prev_q, cnt_cur_q} == 16'h0000) ? COUNT_EXT_ZERO
                : {1'b0, cnt_prev_q, cnt_cur_q}; // see R2, R5
              lba_q <= {high_prev_q, mid_prev_q, low_prev_q,
                high_cur_q, mid_cur_q, low_cur_q}; // see R6
              state_q <= ST_SEEK;
            end else if (opc == OP_VERIFY) begin
              ext_q <= 1'b0; // see R8
              xfer_q <= 1'b0; // see R10
              left_q <= (cnt_cur_q == 8'h00) ? COUNT_28_ZERO
                : {9'h000, cnt_cur_q}; // see R11
              // CHS passes the same byte layout; geometry is the media engine's job
              lba_q <= {20'h0_0000, target_q[3:0], high_cur_q, mid_cur_q, low_cur_q}; // see R12, R19
              state_q <= ST_SEEK;
            end else begin
              err_q[ERR_ABT_BIT] <= 1'b1; // see R17
              err_st_q <= 1'b1;
            end
          end
        end
        ST_SEEK: begin
          if (media_unc) begin
            err_q[ERR_UNC_BIT] <= 1'b1; // see R4, R16
            err_st_q <= 1'b1;
            state_q <= ST_DONE;
          end else if (media_done) begin
            word_q <= 8'h00;
            state_q <= xfer_q ? ST_XFER : ST_NEXT;
          end
        end
        ST_XFER: begin
          if (link.rd && link.addr == SEL_DATA && data_valid_q) begin
            word_q <= word_q + 8'h01; // see R3
            if (word_q == 8'(WORDS_PER_SECTOR - 1)) begin
              state_q <= ST_NEXT;
            end
          end
        end
        ST_NEXT: begin
          left_q <= left_q - 17'h0_0001;
          if (left_q == 17'h0_0001) begin
            state_q <= ST_DONE; // lba_q stays on last processed sector
          end else begin
            lba_q <= lba_q + 48'h0000_0000_0001;
            state_q <= ST_SEEK;
          end
        end
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Word staging from media toward the data register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= 16'h0000;
      data_valid_q <= 1'b0;
    end else if (state_q != ST_XFER) begin
      data_valid_q <= 1'b0;
    end else if (!data_valid_q || (link.rd && link.addr == SEL_DATA)) begin
      data_q <= media_word; // see R3
      data_valid_q <= !(link.rd && link.addr == SEL_DATA && word_q == 8'hff);
    end
  end

  assign media_word_take = state_q == ST_XFER && (!data_valid_q ||
    (link.rd && link.addr == SEL_DATA && word_q != 8'hff));
  assign media_req = state_q == ST_SEEK;
  assign media_lba = lba_q;
  assign link.drq = state_q == ST_XFER && data_valid_q;
  assign link.bsy = state_q != ST_IDLE && !link.drq;

  // ==========================================================
  // Register read mux; high-byte select picks previous bytes
  always_comb begin
    link.rdata = 16'h0000;
    case (link.addr)
      SEL_DATA: link.rdata = data_q;
      SEL_ERR: link.rdata = {8'h00, err_q}; // see R17
      SEL_COUNT: link.rdata = {8'h00, link.hob ? cnt_prev_q : cnt_cur_q};
      SEL_LOW: link.rdata = {8'h00, link.hob ? low_prev_q : low_cur_q}; // see R7
      SEL_MID: link.rdata = {8'h00, link.hob ? mid_prev_q : mid_cur_q};
      SEL_HIGH: link.rdata = {8'h00, link.hob ? high_prev_q : high_cur_q};
      SEL_TARGET: link.rdata = {8'h00, target_q};
      SEL_CMD: link.rdata = {8'h00, link.bsy, !link.bsy, 1'b0, !link.bsy, link.drq,
        2'b00, err_st_q}; // see R17
      default: link.rdata = 16'h0000;
    endcase
  end
endmodule // tf_sector_device

// ==== verilog/tf_sector_host.sv ====
// Host end: loads the task file (previous then current bytes), issues the opcode,
// drains data words while the device requests, and returns the final status.
// Assumes a user that posts one command at a time and takes words as they arrive.
`timescale 1ns/1ps
module tf_sector_host
  import tf_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  tf_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_opcode,
  input wire logic [15:0] cmd_count,
  input wire logic [47:0] cmd_lba,
  input wire logic cmd_drive,
  output logic word_valid,
  output logic [15:0] word_data,
  output logic done,
  output logic [7:0] done_status
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_LOAD = 2'b01,
    H_RUN = 2'b11,
    H_STAT = 2'b10
  } hstate_t;

  hstate_t st_q;
  logic [3:0] step_q;
  logic [7:0] op_q;
  logic [15:0] cnt_q;
  logic [47:0] lba_q;
  logic drv_q;
  logic ext;

  assign ext = op_q == OP_READ_EXT || op_q == OP_VERIFY_EXT;
  assign cmd_ready = st_q == H_IDLE;

  // ==========================================================
  // Write sequence: previous bytes first, then current, then target, then opcode
  always_comb begin
    link.wr = 1'b0;
    link.rd = 1'b0;
    link.addr = SEL_DATA;
    link.hob = 1'b0;
    link.wdata = 16'h0000;
    if (st_q == H_LOAD) begin
      link.wr = 1'b1;
      case (step_q)
        4'h0: begin link.addr = SEL_COUNT; link.wdata = {8'h00, cnt_q[15:8]}; end // see R5
        4'h1: begin link.addr = SEL_LOW; link.wdata = {8'h00, lba_q[31:24]}; end // see R6
        4'h2: begin link.addr = SEL_MID; link.wdata = {8'h00, lba_q[39:32]}; end
        4'h3: begin link.addr = SEL_HIGH; link.wdata = {8'h00, lba_q[47:40]}; end
        4'h4: begin link.addr = SEL_COUNT; link.wdata = {8'h00, cnt_q[7:0]}; end
        4'h5: begin link.addr = SEL_LOW; link.wdata = {8'h00, lba_q[7:0]}; end // see R12
        4'h6: begin link.addr = SEL_MID; link.wdata = {8'h00, lba_q[15:8]}; end
        4'h7: begin link.addr = SEL_HIGH; link.wdata = {8'h00, lba_q[23:16]}; end
        4'h8: begin
          link.addr = SEL_TARGET;
          link.wdata = {8'h00, 1'b1, 1'b1, 1'b1, drv_q,
            ext ? 4'h0 : lba_q[27:24]}; // see R18, R19, R20
        end
        default: begin link.addr = SEL_CMD; link.wdata = {8'h00, op_q}; end // see R1
      endcase
    end else if (st_q == H_RUN && link.drq) begin
      link.rd = 1'b1; // see R3
    end else if (st_q == H_STAT && !link.bsy) begin
      link.rd = 1'b1;
      link.addr = SEL_CMD;
    end
  end

  // ==========================================================
  // Host sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= H_IDLE;
      step_q <= 4'h0;
      op_q <= 8'h00;
      cnt_q <= 16'h0000;
      lba_q <= 48'h0000_0000_0000;
      drv_q <= 1'b0;
    end else begin
      case (st_q)
        H_IDLE: if (cmd_valid) begin
          op_q <= cmd_opcode;
          cnt_q <= cmd_count;
          lba_q <= cmd_lba;
          drv_q <= cmd_drive;
          // 28-bit commands skip the previous-byte writes
          step_q <= (cmd_opcode == OP_READ_EXT || cmd_opcode == OP_VERIFY_EXT) ? 4'h0 : 4'h4;
          st_q <= H_LOAD;
        end
        H_LOAD: begin
          step_q <= step_q + 4'h1;
          if (step_q == 4'h9) begin
            st_q <= H_RUN;
          end
        end
        H_RUN: if (link.bsy || link.drq) begin
          st_q <= H_RUN;
        end else begin
          st_q <= H_STAT;
        end
        H_STAT: if (!link.bsy) begin
          st_q <= H_IDLE;
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // Registered data and completion outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_valid <= 1'b0;
      word_data <= 16'h0000;
      done <= 1'b0;
      done_status <= 8'h00;
    end else begin
      word_valid <= st_q == H_RUN && link.drq;
      if (st_q == H_RUN && link.drq) begin
        word_data <= link.rdata;
      end
      done <= st_q == H_STAT && !link.bsy;
      if (st_q == H_STAT && !link.bsy) begin
        done_status <= link.rdata[7:0];
      end
    end
  end
endmodule // tf_sector_host

// ==== test/ata_read_verify_sector_cmds_properties.sv ====
// Checker for the task-file link joining the host and device ends.
// Assumes one clock and active-low async reset; placed beside the link instance.
`timescale 1ns/1ps
module ata_read_verify_sector_cmds_properties
  import tf_cmd_pkg::*;
#(
  parameter logic DRIVE_ID = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr,
  input wire logic rd,
  input wire logic [2:0] addr,
  input wire logic hob,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic drq,
  input wire logic bsy
);
  // ==========================================================
  // Helper logic
  logic drv_q;
  logic vfy_q;
  logic [7:0] words_q;
  wire op_wr = wr && addr == SEL_CMD && !bsy;
  wire op_ok = wdata[7:0] inside {OP_READ_EXT, OP_VERIFY, 8'h41, OP_VERIFY_EXT};

  // Drive bit of the last idle target write; writes while busy are dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) drv_q <= TARGET_RESET[TGT_DRIVE_BIT];
    else if (wr && addr == SEL_TARGET && !bsy) drv_q <= wdata[TGT_DRIVE_BIT];
  end

  // Verify command in flight
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) vfy_q <= 1'b0;
    else if (op_wr) vfy_q <= op_ok && drv_q == DRIVE_ID && wdata[7:0] != OP_READ_EXT;
    else if (!bsy) vfy_q <= 1'b0;
  end

  // Data reads within one command, modulo one sector
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) words_q <= 8'h00;
    else if (!bsy && !drq) words_q <= 8'h00;
    else if (rd && addr == SEL_DATA) words_q <= words_q + 8'h01;
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_go;
    op_wr && op_ok && drv_q == DRIVE_ID;
  endsequence
  sequence s_bad;
    op_wr && !op_ok;
  endsequence

  AST_BSY_AFTER_OP: assert property (s_go |=> bsy)
    else $error("busy did not follow a valid opcode");
  AST_BAD_OP_IDLE: assert property (s_bad |=> (!bsy) [*2])
    else $error("unknown opcode started a command");
  AST_DRQ_HOLDS: assert property (drq && !(rd && addr == SEL_DATA) |=> drq)
    else $error("data request dropped without a read");
  AST_WORDS_WHOLE: assert property ($fell(bsy) |-> words_q == 8'h00)
    else $error("command ended inside a sector");
  AST_VERIFY_NO_DRQ: assert property (vfy_q |-> !drq)
    else $error("verify offered data");
  AST_STATUS_LIVE: assert property (rd && addr == SEL_CMD |->
    rdata[ST_BSY_BIT] == bsy && rdata[ST_DRQ_BIT] == drq)
    else $error("status bits disagree with link");
  AST_STATUS_ZERO: assert property (rd && addr == SEL_CMD |->
    rdata[5] == 1'b0 && rdata[2] == 1'b0)
    else $error("unused status bit set");
  AST_ERR_ZERO: assert property (rd && addr == SEL_ERR |->
    (rdata[7:0] & 8'haa) == 8'h00)
    else $error("unused error bit set");
endmodule // ata_read_verify_sector_cmds_properties

// ==== test/ata_read_verify_sector_cmds_tb.sv ====
// Testbench joining host and device ends; the bench plays user and media engine.
// Assumes one 250 MHz clock; media answers each sector request at once.
`timescale 1ns/1ps
module ata_read_verify_sector_cmds_tb;
  import tf_cmd_pkg::*;
  // ==========================================================
  // Clock, reset, stimulus
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_drive = 1'b0;
  logic [7:0] cmd_opcode = 8'h00;
  logic [15:0] cmd_count = 16'h0000;
  logic [47:0] cmd_lba = 48'h0000_0000_0000;
  logic media_done = 1'b0;
  logic media_unc = 1'b0;
  logic [15:0] media_word = 16'h0000;
  logic cmd_ready, word_valid, done, media_req, media_word_take;
  logic [15:0] word_data, last_word;
  logic [7:0] done_status, st;
  logic [47:0] media_lba;
  logic [47:0] lba_at [0:1023];
  int sec_n = 0, unc_at = 1 << 30, n_words = 0, failures = 0, n_compared = 0;
  int s0, w0;
  always #2 clk = ~clk;

  tf_link_if tf_link_if_inst (.clk(clk), .rst_n(rst_n));
  tf_sector_device tf_sector_device_inst (.clk(clk), .rst_n(rst_n), .link(tf_link_if_inst),
    .media_req(media_req), .media_lba(media_lba), .media_done(media_done),
    .media_unc(media_unc), .media_word(media_word), .media_word_take(media_word_take));
  tf_sector_host tf_sector_host_inst (.clk(clk), .rst_n(rst_n), .link(tf_link_if_inst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode),
    .cmd_count(cmd_count), .cmd_lba(cmd_lba), .cmd_drive(cmd_drive), .word_valid(word_valid),
    .word_data(word_data), .done(done), .done_status(done_status));
  ata_read_verify_sector_cmds_properties ata_read_verify_sector_cmds_properties_inst (
    .clk(clk), .rst_n(rst_n), .wr(tf_link_if_inst.wr), .rd(tf_link_if_inst.rd),
    .addr(tf_link_if_inst.addr), .hob(tf_link_if_inst.hob), .wdata(tf_link_if_inst.wdata),
    .rdata(tf_link_if_inst.rdata), .drq(tf_link_if_inst.drq), .bsy(tf_link_if_inst.bsy));

  // Task-file contents after a command; the host end never reads these back itself
  wire [47:0] back_lba = {tf_sector_device_inst.high_prev_q, tf_sector_device_inst.mid_prev_q,
    tf_sector_device_inst.low_prev_q, tf_sector_device_inst.high_cur_q,
    tf_sector_device_inst.mid_cur_q, tf_sector_device_inst.low_cur_q};
  wire [15:0] back_cnt = {tf_sector_device_inst.cnt_prev_q, tf_sector_device_inst.cnt_cur_q};
  wire [3:0] back_head = tf_sector_device_inst.target_q[3:0];

  // Media engine answers at once; the word source counts so order shows at the host
  always @(posedge clk) begin
    media_done <= 1'b0;
    media_unc <= 1'b0;
    if (media_req && !media_done && !media_unc) begin
      lba_at[sec_n[9:0]] <= media_lba;
      sec_n <= sec_n + 1;
      if (sec_n == unc_at) media_unc <= 1'b1;
      else media_done <= 1'b1;
    end
    if (media_word_take) media_word <= media_word + 16'h0001;
    if (word_valid) begin
      n_words <= n_words + 1;
      last_word <= word_data;
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One command through the host user port; uncorrectable_flag is the failing sector index
  task automatic run(input logic [7:0] op, input logic [15:0] cnt, input logic [47:0] lba,
      input int uncorrectable_flag, input logic drv = 1'b0);
    s0 = sec_n;
    w0 = n_words;
    unc_at = s0 + uncorrectable_flag;
    @(posedge clk);
    cmd_opcode <= op;
    cmd_count <= cnt;
    cmd_lba <= lba;
    cmd_drive <= drv;
    cmd_valid <= 1'b1;
    do @(negedge clk); while (cmd_ready !== 1'b1);
    @(posedge clk);
    cmd_valid <= 1'b0;
    do @(negedge clk); while (done !== 1'b1);
    st = done_status;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_read_ext;
    run(OP_READ_EXT, 16'h0002, 48'h1234_5678_9abc, 99);
    check(n_words - w0, 48'd512);
    check(lba_at[s0[9:0]], 48'h1234_5678_9abc);
    check(last_word, 16'(n_words - 1));
    check(st[ST_ERR_BIT], 1'b0);
    check(back_cnt, 16'h0000);
    $display("read_ext finished");
  endtask

  task automatic t_read_unc;
    run(OP_READ_EXT, 16'h0003, 48'h0000_0000_00ff, 1);
    check(sec_n - s0, 48'd2);
    check(n_words - w0, 48'd256);
    check(lba_at[unc_at[9:0]], 48'h0000_0000_0100);
    check(back_lba, 48'h0000_0000_0100);
    check(back_cnt, 16'h0002);
    check(st[ST_ERR_BIT], 1'b1);
    $display("read_unc finished");
  endtask

  // Every verify opcode, with the zero-count and high-byte count cases
  task automatic t_verify;
    logic [7:0] ops [3] = '{OP_VERIFY, 8'h41, OP_VERIFY_EXT};
    logic [15:0] cnts [3] = '{16'h0000, 16'h0003, 16'h0100};
    int secs [3] = '{256, 3, 256};
    for (int i = 0; i < 3; i++) begin
      run(ops[i], cnts[i], 48'h0000_0abc_def0, 999);
      check(sec_n - s0, secs[i]);
      check(n_words - w0, 48'd0);
      check(lba_at[s0[9:0]][27:0], 28'habc_def0);
      if (i < 2) begin
        check(back_cnt[7:0], 8'h00);
        check({back_head, back_lba[23:0]}, 28'habc_def0 + 28'(secs[i] - 1));
      end
    end
    $display("verify finished");
  endtask

  task automatic t_verify_unc;
    run(OP_VERIFY_EXT, 16'h0004, 48'h0000_0000_0010, 2);
    check(sec_n - s0, 48'd3);
    check(st[ST_ERR_BIT], 1'b1);
    check(back_lba, 48'h0000_0000_0012);
    run(OP_VERIFY, 16'h0005, 48'h0000_0000_0020, 1);
    check(sec_n - s0, 48'd2);
    check(back_cnt[7:0], 8'h04);
    check(st[ST_ERR_BIT], 1'b1);
    $display("verify_unc finished");
  endtask

  // A command aimed at the other drive on the cable must leave this device idle
  task automatic t_other_drive;
    run(OP_VERIFY_EXT, 16'h0001, 48'h0000_0000_0030, 9, 1'b1);
    check(sec_n - s0, 48'd0);
    check(n_words - w0, 48'd0);
    $display("other_drive finished");
  endtask

  task automatic t_bad_op;
    run(8'h99, 16'h0001, 48'h0000_0000_0000, 9);
    check(sec_n - s0, 48'd0);
    check(st[ST_ERR_BIT], 1'b1);
    $display("bad_op finished");
  endtask

  // ==========================================================
  // Verdict and run control
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the roughly 2,500 cycles the tests need
  initial begin
    #200_000;
    failures++;
    stop_test();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_read_ext();
    t_read_unc();
    t_verify();
    t_verify_unc();
    t_bad_op();
    t_other_drive();
    stop_test();
  end
endmodule // ata_read_verify_sector_cmds_tb
